// File: logic/qpc_counter.v
// Four-channel pulse counter with compare table and Wishbone register access
// Operation
// [R01] Each of four ports counts pulses up to 500 kHz, mode-limited
// [R02] Modes: quadrature 1x/2x/4x, separate up/down pulses, pulse plus direction
// [R03] Count equal to target loads that entry's pattern into result bits
// [R04] Count inside lower-upper range loads that entry's pattern into result bits
// [R05] Every table entry carries its own programmable output pattern
// [R06] Up to four external output lines follow the chosen pattern
// [R07] Compare matches raise no interrupt; only result bits update
// [R08] Error indicator lit on bad configuration or count overflow/underflow
// [R09] Host loads tables by command, comparison started then or later
// [R10] Mode command starts or stops comparison or presets a count
// [R11] Read command returns count or status of selected channel
// [R12] Each instance keeps fully independent counters, tables and outputs
// [R13] Count given as two 16-bit words, BCD or hex, refreshed per scan
// [R14] Status bit 12 running, 13 comparing, 14 overflow, 15 setting error
// [R15] Ch1-2 clear on index when reset bit set; ch3-4 on reset rising edge
// [R16] Comparison starts on start-bit rise, stops on its fall
// [R17] Quadrature direction follows phase lead; 4x all edges, 2x A, 1x one
`timescale 1ns/100ps
`include "qpc_defs.vh"
module qpc_counter #(
  parameter NCH = 4,
  parameter NENT = 4,
  parameter SCAN = `QPC_SCAN_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [NCH-1:0] pha_i,
  input wire [NCH-1:0] phb_i,
  input wire [NCH-1:0] idx_i,
  output reg [NCH*8-1:0] result_int_o,
  output reg [3:0] ext_out_o,
  output reg err_led_o,
  output reg irq_o
);
  // Every state lives inside this module, so two instances share nothing (see [R12])
  reg [31:0] cfg [0:NCH-1];
  reg [31:0] ctrl;
  reg [31:0] cmd_data;
  reg [31:0] rd_data;
  reg [31:0] tbl_lo [0:NCH*NENT-1];
  reg [31:0] tbl_hi [0:NCH*NENT-1];
  reg [7:0] tbl_pat [0:NCH*NENT-1];
  reg [31:0] cnt [0:NCH-1];
  reg [31:0] snap [0:NCH-1];
  reg [NCH-1:0] cmp_on;
  reg [NCH-1:0] ovf;
  reg [NCH-1:0] cfg_err;
  reg [7:0] pat [0:NCH-1];
  reg [NCH-1:0] a_s1, a_s2, a_d, b_s1, b_s2, b_d, z_s1, z_s2, z_d;
  reg [31:0] ctrl_d;
  reg [15:0] scan_cnt;
  reg [3:0] stat;
  reg [3:0] mask;
  reg [3:0] next_stat;
  reg [NCH-1:0] wrap_ev;
  wire req = cyc_i & stb_i & ~ack_o;
  // Writes land at the edge where the master samples ack, not at the take edge
  wire wr = cyc_i & stb_i & we_i & ack_o;
  // Table entries sit eight bytes apart so all sixteen fit the byte address
  wire [7:0] tbl_off = adr_i - `QPC_TBL_BASE;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [2:0] cmd_op = dat_i[2:0];
  wire [1:0] cmd_ch = dat_i[5:4];
  wire scan_tick = (scan_cnt == 16'h0000);
  integer i, e;
  // Binary to 8-digit BCD, only valid below 10^8
  function [31:0] to_bcd;
    input [31:0] v;
    integer k;
    reg [31:0] r;
    reg [31:0] t;
    reg [31:0] d;
    begin
      r = 32'h0000_0000;
      t = v;
      for (k = 0; k < 8; k = k + 1)
      begin
        d = t % 10;
        r[k*4 +: 4] = d[3:0];
        t = t / 10;
      end
      to_bcd = r;
    end
  endfunction
  function [31:0] rmw;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      rmw = (old & ~m) | (nw & m);
    end
  endfunction
  // Pin synchronisers; the second and third stages feed edge detection (see [R01])
  always @(posedge clk_i)
  begin
    a_s1 <= pha_i;
    a_s2 <= a_s1;
    a_d <= a_s2;
    b_s1 <= phb_i;
    b_s2 <= b_s1;
    b_d <= b_s2;
    z_s1 <= idx_i;
    z_s2 <= z_s1;
    z_d <= z_s2;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
      scan_cnt <= 16'h0000;
    else if (scan_tick)
      scan_cnt <= SCAN[15:0] - 16'h0001;
    else
      scan_cnt <= scan_cnt - 16'h0001;
  end
  // Counting, compare and the host command path
  always @(posedge clk_i)
  begin : count_blk
    reg up, dn, ea, eb;
    reg [31:0] maxv;
    reg hit;
    reg [31:0] base;
    up = 1'b0;
    dn = 1'b0;
    ea = 1'b0;
    eb = 1'b0;
    maxv = 32'h0000_0000;
    hit = 1'b0;
    base = 32'h0000_0000;
    if (rst_i)
    begin
      for (i = 0; i < NCH; i = i + 1)
      begin
        cnt[i] <= 32'h0000_0000;
        snap[i] <= 32'h0000_0000;
        pat[i] <= 8'h00;
      end
      cmp_on <= {NCH{1'b0}};
      ovf <= {NCH{1'b0}};
      cfg_err <= {NCH{1'b0}};
      ctrl_d <= 32'h0000_0000;
      wrap_ev <= {NCH{1'b0}};
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      ctrl_d <= ctrl;
      wrap_ev <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
      begin
        ea = a_s2[i] ^ a_d[i];
        eb = b_s2[i] ^ b_d[i];
        up = 1'b0;
        dn = 1'b0;
        maxv = cfg[i][31:`QPC_CFG_MAX_LSB] == 24'h0 ? 32'hffff_ffff :
          {8'h00, cfg[i][31:`QPC_CFG_MAX_LSB]};
        // Mode 3 and multiplier 3 are not defined (see [R08])
        cfg_err[i] <= (cfg[i][1:0] == 2'h3) || (cfg[i][3:2] == 2'h3);
        case (cfg[i][1:0])
          `QPC_MODE_QUAD:
          begin
            // A leading B counts up (see [R17])
            case (cfg[i][3:2])
              2'h0:
              begin
                up = ea & a_s2[i] & ~b_s2[i];
                dn = ea & ~a_s2[i] & ~b_s2[i];
              end
              2'h1:
              begin
                up = ea & (a_s2[i] ^ b_s2[i]);
                dn = ea & ~(a_s2[i] ^ b_s2[i]);
              end
              default:
              begin
                up = (ea & (a_s2[i] ^ b_s2[i])) | (eb & ~(a_s2[i] ^ b_s2[i]));
                dn = (ea & ~(a_s2[i] ^ b_s2[i])) | (eb & (a_s2[i] ^ b_s2[i]));
              end
            endcase
          end
          `QPC_MODE_UPDN:
          begin
            up = ea & a_s2[i];
            dn = eb & b_s2[i];
          end
          `QPC_MODE_PDIR:
          begin
            up = ea & a_s2[i] & ~b_s2[i];
            dn = ea & a_s2[i] & b_s2[i];
          end
          default:
          begin
            up = 1'b0;
            dn = 1'b0;
          end
        endcase // see [R02]
        if (ctrl[`QPC_CTRL_RUN_LSB + i])
        begin
          if (up & ~dn)
          begin
            if (cnt[i] == maxv)
            begin
              cnt[i] <= 32'h0000_0000;
              ovf[i] <= 1'b1; // see [R08]
              wrap_ev[i] <= 1'b1;
            end
            else
              cnt[i] <= cnt[i] + 32'h0000_0001;
          end
          else if (dn & ~up)
          begin
            if (cnt[i] == 32'h0000_0000)
            begin
              cnt[i] <= maxv;
              ovf[i] <= 1'b1; // see [R08]
              wrap_ev[i] <= 1'b1;
            end
            else
              cnt[i] <= cnt[i] - 32'h0000_0001;
          end
        end
        if (i < 2)
        begin
          if (ctrl[`QPC_CTRL_RST_LSB + i] & z_s2[i] & ~z_d[i])
            cnt[i] <= 32'h0000_0000; // see [R15]
        end
        else if (ctrl[`QPC_CTRL_RST_LSB + i] & ~ctrl_d[`QPC_CTRL_RST_LSB + i])
        begin
          cnt[i] <= 32'h0000_0000; // see [R15]
          ovf[i] <= 1'b0;
        end
        if (ctrl[`QPC_CTRL_CMP_LSB + i] & ~ctrl_d[`QPC_CTRL_CMP_LSB + i])
          cmp_on[i] <= 1'b1; // see [R16]
        else if (~ctrl[`QPC_CTRL_CMP_LSB + i] & ctrl_d[`QPC_CTRL_CMP_LSB + i])
          cmp_on[i] <= 1'b0; // see [R16]
        // Last matching entry wins; no match keeps the last pattern
        if (cmp_on[i])
        begin
          for (e = 0; e < NENT; e = e + 1)
          begin
            if (cfg[i][`QPC_CFG_RANGE])
              hit = cnt[i] >= tbl_lo[i*NENT+e] && cnt[i] <= tbl_hi[i*NENT+e]; // see [R04]
            else
              hit = cnt[i] == tbl_lo[i*NENT+e]; // see [R03]
            if (hit)
              pat[i] <= tbl_pat[i*NENT+e]; // see [R05]
          end
        end
        if (scan_tick)
          snap[i] <= cfg[i][`QPC_CFG_BCD] ? to_bcd(cnt[i]) : cnt[i]; // see [R13]
      end
      if (wr && adr_i == `QPC_CMD && sel_i[0])
      begin
        case (cmd_op)
          `QPC_CMD_START, `QPC_CMD_TBL_START: cmp_on[cmd_ch] <= 1'b1; // see [R10] [R09]
          `QPC_CMD_STOP: cmp_on[cmd_ch] <= 1'b0; // see [R10]
          `QPC_CMD_PRESET: cnt[cmd_ch] <= cmd_data; // see [R10]
          `QPC_CMD_RD_LO: rd_data <= {16'h0000, snap[cmd_ch][15:0]}; // see [R11]
          `QPC_CMD_RD_HI: rd_data <= {16'h0000, snap[cmd_ch][31:16]}; // see [R11]
          `QPC_CMD_RD_STAT:
          begin
            base = 32'h0000_0000;
            base[`QPC_ST_RUN] = ctrl[`QPC_CTRL_RUN_LSB + cmd_ch];
            base[`QPC_ST_CMP] = cmp_on[cmd_ch];
            base[`QPC_ST_OVF] = ovf[cmd_ch];
            base[`QPC_ST_ERR] = cfg_err[cmd_ch];
            base[11:0] = {4'h0, pat[cmd_ch]};
            rd_data <= base; // see [R14] [R11]
          end
          default: rd_data <= rd_data;
        endcase
      end
    end
  end
  // Register writes, interrupt status and the bus answer
  always @*
  begin
    next_stat = stat | {wrap_ev != {NCH{1'b0}}, |cfg_err, 2'b00};
    if (wr && adr_i == `QPC_IRQ_STAT)
      next_stat = (stat & ~(dat_i[3:0] & wmask[3:0])) | {wrap_ev != {NCH{1'b0}}, |cfg_err, 2'b00};
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < NCH; i = i + 1)
        cfg[i] <= 32'h0000_0000;
      for (i = 0; i < NCH*NENT; i = i + 1)
      begin
        tbl_lo[i] <= 32'h0000_0000;
        tbl_hi[i] <= 32'h0000_0000;
        tbl_pat[i] <= 8'h00;
      end
      ctrl <= 32'h0000_0000;
      cmd_data <= 32'h0000_0000;
      stat <= 4'h0;
      mask <= 4'h0;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      result_int_o <= {NCH*8{1'b0}};
      ext_out_o <= 4'h0;
      err_led_o <= 1'b0;
    end
    else
    begin
      ack_o <= req;
      stat <= next_stat;
      // Overflow and config error only; compare matches never interrupt (see [R07])
      irq_o <= |(next_stat & mask);
      err_led_o <= |ovf | |cfg_err; // see [R08]
      for (i = 0; i < NCH; i = i + 1)
        result_int_o[i*8 +: 8] <= pat[i];
      // External lines 1..4 come from bits 0..3 of each channel's pattern
      ext_out_o <= pat[0][3:0] | pat[1][3:0] | pat[2][3:0] | pat[3][3:0]; // see [R06]
      if (wr)
      begin
        if (adr_i < 8'h10 && adr_i[1:0] == 2'b00 && adr_i != `QPC_CMD)
        begin
          if (adr_i == `QPC_CH_CFG)
            cfg[dat_i[31:30]] <= {2'b00, dat_i[29:0]};
          else if (adr_i == `QPC_CTRL)
            ctrl <= rmw(ctrl, dat_i, wmask);
          else
            cmd_data <= rmw(cmd_data, dat_i, wmask);
        end
        else if (adr_i == `QPC_IRQ_MASK)
          mask <= dat_i[3:0];
        else if (adr_i >= `QPC_TBL_BASE && tbl_off < 8'h80 && adr_i[2:0] == 3'h0)
        begin
          tbl_lo[tbl_off[6:3]] <= cmd_data; // see [R09]
          tbl_hi[tbl_off[6:3]] <= dat_i; // see [R09]
          tbl_pat[tbl_off[6:3]] <= dat_i[7:0]; // see [R05]
        end
      end
      if (req & ~we_i)
      begin
        case (adr_i)
          `QPC_CTRL: dat_o <= ctrl;
          `QPC_CMD_DATA: dat_o <= cmd_data;
          `QPC_RD_DATA: dat_o <= rd_data;
          `QPC_IRQ_STAT: dat_o <= {28'h0, stat};
          `QPC_IRQ_MASK: dat_o <= {28'h0, mask};
          `QPC_OUT_STAT: dat_o <= {27'h0, err_led_o, ext_out_o};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// File: shared/qpc_defs.vh
// Register offsets, field positions, command codes and timing counts for the pulse counter
`ifndef QPC_DEFS_VH
`define QPC_DEFS_VH
`define QPC_CH_CFG 8'h00
`define QPC_CTRL 8'h04
`define QPC_CMD 8'h08
`define QPC_CMD_DATA 8'h0c
`define QPC_RD_DATA 8'h10
`define QPC_IRQ_STAT 8'h14
`define QPC_IRQ_MASK 8'h18
`define QPC_OUT_STAT 8'h1c
`define QPC_TBL_BASE 8'h40
`define QPC_CFG_MODE_LSB 0
`define QPC_CFG_MULT_LSB 2
`define QPC_CFG_BCD 4
`define QPC_CFG_RANGE 5
`define QPC_CFG_MAX_LSB 8
`define QPC_CTRL_RST_LSB 0
`define QPC_CTRL_CMP_LSB 8
`define QPC_CTRL_RUN_LSB 16
`define QPC_CMD_START 3'h1
`define QPC_CMD_STOP 3'h2
`define QPC_CMD_PRESET 3'h3
`define QPC_CMD_RD_LO 3'h4
`define QPC_CMD_RD_HI 3'h5
`define QPC_CMD_RD_STAT 3'h6
`define QPC_CMD_TBL_START 3'h7
`define QPC_ST_RUN 12
`define QPC_ST_CMP 13
`define QPC_ST_OVF 14
`define QPC_ST_ERR 15
`define QPC_MODE_QUAD 2'h0
`define QPC_MODE_UPDN 2'h1
`define QPC_MODE_PDIR 2'h2
`define QPC_MAX_RATE_KHZ 500
`define QPC_CLK_MHZ 100
`define QPC_SCAN_CYCLES ((`QPC_CLK_MHZ * 1000) / `QPC_MAX_RATE_KHZ)
`endif

// File: test/qpc_checker.sv
// Bus, output and reset checks bound onto the pulse counter
`timescale 1ns/100ps
module qpc_checker #(parameter NCH = 4) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire [NCH*8-1:0] result_int_o,
  input wire [3:0] ext_out_o,
  input wire err_led_o,
  input wire irq_o
);
  reg [3:0] orv;
  integer k;
  always @*
  begin
    orv = 4'h0;
    for (k = 0; k < NCH; k = k + 1)
      orv = orv | result_int_o[k*8+:4];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_answer:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
  a_ack_cause:
    assert property (ack_o |-> $past(cyc_i) && $past(stb_i)) else $error("ack without request");
  a_dat_hold:
    assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
  a_unmapped_zero:
    assert property (ack_o && !we_i && adr_i inside {[8'h20:8'h3c]} |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
  // Both outputs load from the patterns at the same edge; the check still waits two quiet cycles
  a_ext_follow:
    assert property ($stable(result_int_o) [*2] |-> ext_out_o == orv)
      else $error("external lines differ from patterns");
  a_irq_cause:
    assert property ($rose(irq_o) |-> ##[0:2] err_led_o) else $error("irq without error");
  a_reset_quiet:
    assert property ($fell(rst_i) |-> !ack_o && !irq_o && !err_led_o && result_int_o == 0)
      else $error("outputs not clear after reset");
  c_read: cover property (ack_o && !we_i);
  c_irq: cover property ($rose(irq_o));
  c_ext: cover property (ext_out_o != 4'h0);
endmodule
bind qpc_counter qpc_checker #(.NCH(NCH)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
  .ack_o(ack_o), .result_int_o(result_int_o), .ext_out_o(ext_out_o),
  .err_led_o(err_led_o), .irq_o(irq_o));

// File: test/qpc_enc_model.sv
// Pulse source model for the four counter input ports
`timescale 1ns/100ps
module qpc_enc_model (
  input wire clk_i,
  output reg [3:0] pha_o = 4'h0,
  output reg [3:0] phb_o = 4'h0,
  output reg [3:0] idx_o = 4'h0
);
  // Quadrature edges 50 cycles apart give a 500 kHz period, the fastest the ports take
  task quad(input integer ch, input integer up, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1)
    begin
      repeat (50) @(posedge clk_i);
      if ((pha_o[ch] == phb_o[ch]) == (up != 0))
        pha_o[ch] <= ~pha_o[ch];
      else
        phb_o[ch] <= ~phb_o[ch];
    end
  endtask
  task pulse(input integer ch, input integer n);
    integer i;
    for (i = 0; i < 2 * n; i = i + 1)
    begin
      repeat (100) @(posedge clk_i);
      pha_o[ch] <= ~pha_o[ch];
    end
  endtask
  task index_pulse(input integer ch);
  begin
    repeat (50) @(posedge clk_i);
    idx_o[ch] <= 1'b1;
    repeat (50) @(posedge clk_i);
    idx_o[ch] <= 1'b0;
  end
  endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the four-channel pulse counter
`timescale 1ns/100ps
`include "qpc_defs.vh"
`define CHK(a, e) begin n_compared = n_compared + 1; if ((a) !== (e)) begin bad_count = bad_count + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  reg clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, rdat;
  wire [31:0] dat_o;
  wire [31:0] result_int_o;
  wire [3:0] pha, phb, idx, ext_out_o;
  wire ack_o, err_led_o, irq_o;
  integer bad_count = 0, n_compared = 0, cycles = 0, i;
  always #5 clk_i = ~clk_i;
  qpc_enc_model i_enc (.clk_i(clk_i), .pha_o(pha), .phb_o(phb), .idx_o(idx));
  qpc_counter #(.SCAN(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .pha_i(pha), .phb_i(phb), .idx_i(idx), .result_int_o(result_int_o),
    .ext_out_o(ext_out_o), .err_led_o(err_led_o), .irq_o(irq_o));
  task complete_run;
  begin
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // Request held until ack is seen at an edge, then one idle cycle
  task wb(input [7:0] a, input w, input [31:0] d);
  begin
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task rc(input [7:0] a, input [31:0] e);
  begin
    wb(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  end
  endtask
  // Waits out sync stages and the snapshot period before reading
  task cnt(input [1:0] ch, input [31:0] e);
  begin
    repeat (20) @(posedge clk_i);
    wr(`QPC_CMD, {26'h0, ch, 4'h4});
    rc(`QPC_RD_DATA, e);
  end
  endtask
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`QPC_IRQ_MASK, 32'h0);
    rc(8'h20, 32'h0);
    wr(`QPC_CH_CFG, 32'h0000_0020);
    wr(`QPC_CH_CFG, 32'h4000_0004);
    wr(`QPC_CH_CFG, 32'h8000_0008);
    wr(`QPC_CH_CFG, 32'hc000_0401);
    wr(`QPC_CTRL, 32'h000f_0000);
    for (i = 0; i < 3; i = i + 1)
      i_enc.quad(i, 1, 8);
    for (i = 0; i < 3; i = i + 1)
      cnt(i, 32'd2 << i);
    i_enc.quad(2, 0, 3);
    cnt(2, 32'd5);
    i_enc.pulse(3, 3);
    cnt(3, 32'd3);
    wr(`QPC_CMD_DATA, 32'h1);
    wr(`QPC_TBL_BASE, 32'h3);
    wr(`QPC_CMD, 32'h07);
    repeat (10) @(posedge clk_i);
    `CHK(result_int_o[7:0], 8'h03)
    `CHK(ext_out_o, 4'h3)
    wr(`QPC_CMD, 32'h06);
    rc(`QPC_RD_DATA, 32'h0000_3003);
    wr(`QPC_CMD_DATA, 32'h4);
    wr(8'h60, 32'h4);
    wr(`QPC_CMD, 32'h11);
    repeat (10) @(posedge clk_i);
    `CHK(result_int_o[15:8], 8'h04)
    `CHK(ext_out_o, 4'h7)
    wr(`QPC_CMD, 32'h02);
    wr(`QPC_CMD, 32'h06);
    rc(`QPC_RD_DATA, 32'h0000_1003);
    wr(`QPC_IRQ_MASK, 32'h8);
    i_enc.pulse(3, 2);
    repeat (10) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    `CHK(err_led_o, 1'b1)
    rc(`QPC_IRQ_STAT, 32'h8);
    wr(`QPC_IRQ_MASK, 32'h0);
    // The interrupt output follows the new mask one edge after the write
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(`QPC_IRQ_STAT, 32'h8);
    rc(`QPC_IRQ_STAT, 32'h0);
    wr(`QPC_CTRL, 32'h000f_0008);
    cnt(3, 32'h0);
    `CHK(err_led_o, 1'b0)
    wr(`QPC_CMD_DATA, 32'h100);
    wr(`QPC_CMD, 32'h23);
    cnt(2, 32'h100);
    wr(`QPC_CH_CFG, 32'h8000_0018);
    wr(`QPC_CMD_DATA, 32'h00bc_614e);
    wr(`QPC_CMD, 32'h23);
    cnt(2, 32'h5678);
    wr(`QPC_CMD, 32'h25);
    rc(`QPC_RD_DATA, 32'h1234);
    wr(`QPC_CTRL, 32'h000f_0009);
    i_enc.index_pulse(0);
    cnt(0, 32'h0);
    wr(`QPC_CH_CFG, 32'hc000_0003);
    repeat (4) @(posedge clk_i);
    `CHK(err_led_o, 1'b1)
    rc(`QPC_IRQ_STAT, 32'h4);
    wr(`QPC_CH_CFG, 32'hc000_0002);
    i_enc.pulse(3, 2);
    cnt(3, 32'h2);
    complete_run;
  end
endmodule
